// ==== design/mcb_pkg.sv ====
package mcb_pkg;
	localparam int CLK_MHZ = 100;
	localparam int BIT_TIME_NS = 10;
	localparam int BIT_CYC = (BIT_TIME_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (BIT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CFG_FIRST = 11;
	localparam int CFG_BYTES = 8;
	localparam logic [4:0] CFG_LAST_IDX = 5'h12;
	// Defaults for bytes 11..18, byte 11 in the low lane
	localparam logic [63:0] CFG_RESET = 64'h72_40_00_80_F2_00_60_00;
	localparam int IFS_LSB = 4;
	localparam int LPM_BIT = 0;
	localparam int CDT_OPT_BIT = 7;
	localparam int SHORT_CRC_BIT = 5;
	localparam int IGN_UL_BIT = 4;
	localparam int WAW_BIT = 2;
	localparam int BC_DIS_BIT = 1;
	localparam int PROMISC_BIT = 0;
	localparam int LONG_OK_BIT = 3;
	localparam int CRC_XFER_BIT = 2;
	localparam int PAD_EN_BIT = 1;
	localparam int STRIP_EN_BIT = 0;
	localparam int PFC_THR_LSB = 4;
	localparam logic [2:0] PFC_OFF = 3'h7;
	localparam logic [11:0] IFS_UNIT_BITS = 12'h010;
	localparam logic [11:0] SLOT_BITS = 12'h200;
	localparam logic [15:0] MAX_DATA = 16'h05DC;
	localparam logic [15:0] HDR_LEN = 16'h000E;
	localparam logic [15:0] VLAN_EXTRA = 16'h0004;
	localparam logic [15:0] FCS_HDR_LEN = 16'h0012;
	localparam logic [6:0] MIN_NO_FCS = 7'h3C;
	localparam logic [7:0] PAD_BYTE = 8'h7E;
	localparam logic [15:0] TYPE_VLAN = 16'h8100;
	localparam logic [15:0] TYPE_FC = 16'h8808;
	localparam logic [15:0] ARP_HI_OFS = 16'h0028;
	localparam logic [15:0] ARP_LO_OFS = 16'h0029;
	localparam logic [15:0] PRIO_OFS = 16'h0013;
	localparam logic [4:0] FCS_LEN = 5'h04;

	function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = ((r[0] ^ d[i]) ? 32'hEDB88320 : 32'h00000000) ^ (r >> 1);
		return r;
	endfunction : crc32_byte

	function automatic logic [15:0] short_crc_select_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = ((r[0] ^ d[i]) ? 16'h8408 : 16'h0000) ^ (r >> 1);
		return r;
	endfunction : short_crc_select_byte
endpackage : mcb_pkg

// ==== design/mcb_byte_if.sv ====
`timescale 1ns/100ps
interface mcb_byte_if;
	logic valid;
	logic [7:0] data;
	logic last;
	logic fcs;
	modport src(output valid, output data, output last, output fcs);
	modport snk(input valid, input data, input last, input fcs);
endinterface : mcb_byte_if

// ==== design/mcb_defer_timer.sv ====
`timescale 1ns/100ps
module mcb_defer_timer
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bit_tick,
	input wire logic load,
	input wire logic [11:0] load_bits,
	output logic expired
);
	logic [11:0] cnt_reg;

	// Reloaded while the medium is busy, so counting starts at the later event
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cnt_reg <= 12'h000;
		else if (load)
			cnt_reg <= load_bits;
		else if (bit_tick && cnt_reg != 12'h000)
			cnt_reg <= cnt_reg - 12'h001;
	end

	assign expired = (cnt_reg == 12'h000) && !load;
endmodule : mcb_defer_timer

// ==== design/mcb_rx_delay.sv ====
`timescale 1ns/100ps
module mcb_rx_delay
(
	input wire logic clk,
	input wire logic rst_b,
	mcb_byte_if.snk in_b,
	mcb_byte_if.src out_b
);
	logic [31:0] hold_reg;
	logic [2:0] fill_reg;
	logic [2:0] flush_reg;

	// Holds the newest four bytes; they are the FCS once the last byte arrives
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hold_reg <= 32'h00000000;
			fill_reg <= 3'h0;
			flush_reg <= 3'h0;
			out_b.valid <= 1'b0;
			out_b.data <= 8'h00;
			out_b.last <= 1'b0;
			out_b.fcs <= 1'b0;
		end
		else if (in_b.valid)
		begin
			hold_reg <= {in_b.data, hold_reg[31:8]};
			fill_reg <= in_b.last ? 3'h0 : (fill_reg == 3'h4 ? 3'h4 : fill_reg + 3'h1);
			flush_reg <= in_b.last ? 3'h4 : 3'h0;
			out_b.valid <= fill_reg == 3'h4;
			out_b.data <= hold_reg[7:0];
			out_b.last <= 1'b0;
			out_b.fcs <= 1'b0;
		end
		else if (flush_reg != 3'h0)
		begin
			hold_reg <= {8'h00, hold_reg[31:8]};
			flush_reg <= flush_reg - 3'h1;
			out_b.valid <= 1'b1;
			out_b.data <= hold_reg[7:0];
			out_b.last <= flush_reg == 3'h1;
			out_b.fcs <= 1'b1;
		end
		else
		begin
			out_b.valid <= 1'b0;
			out_b.last <= 1'b0;
			out_b.fcs <= 1'b0;
		end
	end
endmodule : mcb_rx_delay

// ==== design/mcb_mac_cfg.sv ====
`timescale 1ns/100ps
module mcb_mac_cfg
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cfg_wr,
	input wire logic [4:0] cfg_idx,
	input wire logic [7:0] cfg_data,
	input wire logic cfg_commit,
	input wire logic [47:0] individual_station_address,
	input wire logic carrier_sense_pin,
	input wire logic collision_detect_input,
	input wire logic backoff_done,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	output logic rx_out_valid,
	output logic [7:0] rx_out_data,
	output logic rx_out_last,
	output logic rx_stat_valid,
	output logic rx_stat_accept,
	output logic rx_stat_long,
	output logic rx_stat_ok,
	output logic rx_stat_arp_match,
	output logic rx_stat_pause_low,
	input wire logic tx_in_valid,
	input wire logic [7:0] tx_in_data,
	input wire logic tx_in_last,
	output logic tx_in_ready,
	output logic tx_out_valid,
	output logic [7:0] tx_out_data,
	output logic tx_out_last,
	input wire logic tx_out_ready,
	output logic defer_ok,
	output logic modified_backoff,
	output logic short_crc_select,
	output logic priority_fc_enable,
	output logic [15:0] fc_pause_time
);
	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_PAD, TX_FCS} mcb_tx_e;

	logic [7:0] shadow_reg [0:mcb_pkg::CFG_BYTES-1];
	logic [7:0] act_reg [0:mcb_pkg::CFG_BYTES-1];

	// Staged bytes move to the live set only on commit
	for (genvar g = 0; g < mcb_pkg::CFG_BYTES; g++)
	begin : g_cfg
		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
				shadow_reg[g] <= mcb_pkg::CFG_RESET[8*g +: 8];
			else if (cfg_wr && cfg_idx == 5'(mcb_pkg::CFG_FIRST + g))
				shadow_reg[g] <= cfg_data;
		end

		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
				act_reg[g] <= mcb_pkg::CFG_RESET[8*g +: 8];
			else if (cfg_commit)
				act_reg[g] <= shadow_reg[g];
		end
	end

	logic [2:0] lin_prio;
	logic [3:0] ifs_val;
	logic lp_mode;
	logic [7:0] ip_lo;
	logic [7:0] ip_hi;
	logic [7:0] b15;
	logic [7:0] b18;
	logic [2:0] pfc_thr;

	assign lin_prio = act_reg[0][2:0];
	assign ifs_val = act_reg[1][mcb_pkg::IFS_LSB +: 4];
	assign lp_mode = act_reg[1][mcb_pkg::LPM_BIT];
	assign ip_lo = act_reg[2];
	assign ip_hi = act_reg[3];
	assign b15 = act_reg[4];
	assign b18 = act_reg[7];
	assign pfc_thr = b18[mcb_pkg::PFC_THR_LSB +: 3];

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			modified_backoff <= 1'b0;
			short_crc_select <= 1'b0;
			priority_fc_enable <= 1'b0;
			fc_pause_time <= 16'h0000;
		end
		else
		begin
			modified_backoff <= b15[mcb_pkg::WAW_BIT];
			short_crc_select <= b15[mcb_pkg::SHORT_CRC_BIT];
			priority_fc_enable <= pfc_thr != mcb_pkg::PFC_OFF;
			fc_pause_time <= {act_reg[6], act_reg[5]};
		end
	end

	// Pin synchronisers
	logic [1:0] crs_sync;
	logic [1:0] cdt_sync;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			crs_sync <= 2'h0;
			cdt_sync <= 2'h0;
		end
		else
		begin
			crs_sync <= {crs_sync[0], carrier_sense_pin};
			cdt_sync <= {cdt_sync[0], collision_detect_input};
		end
	end

	// Bit-time enable
	logic [7:0] div_reg;
	logic bit_tick;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			div_reg <= 8'h00;
		else if (bit_tick)
			div_reg <= 8'h00;
		else
			div_reg <= div_reg + 8'h01;
	end

	assign bit_tick = div_reg == 8'(mcb_pkg::BIT_CYC - 1);

	// Deferral
	mcb_tx_e tx_state_reg;
	logic tx_active;
	logic carrier;
	logic busy;
	logic own_tx_seen_reg;
	logic busy_prev_reg;
	logic timer_load;
	logic [11:0] ifs_bits;
	logic [11:0] slot_wait;
	logic [11:0] load_bits;
	logic timer_done;

	assign tx_active = tx_state_reg != TX_IDLE || tx_out_valid;
	assign carrier = crs_sync[1] || (b15[mcb_pkg::CDT_OPT_BIT] && cdt_sync[1] && tx_active);
	assign busy = carrier || tx_active;
	assign ifs_bits = 12'(ifs_val) * mcb_pkg::IFS_UNIT_BITS;
	assign slot_wait = 12'(lin_prio) * mcb_pkg::SLOT_BITS;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			own_tx_seen_reg <= 1'b0;
			busy_prev_reg <= 1'b0;
		end
		else
		begin
			busy_prev_reg <= busy;
			if (busy && !busy_prev_reg)
				own_tx_seen_reg <= tx_active;
			else if (tx_active)
				own_tx_seen_reg <= 1'b1;
		end
	end

	always_comb
	begin
		timer_load = 1'b0;
		load_bits = ifs_bits;
		if (busy)
		begin
			timer_load = 1'b1;
			if (own_tx_seen_reg || tx_active || lp_mode)
				load_bits = ifs_bits + slot_wait;
		end
		else if (backoff_done)
		begin
			timer_load = 1'b1;
			load_bits = slot_wait;
		end
	end

	mcb_defer_timer u_defer
	(
		.clk(clk),
		.rst_b(rst_b),
		.bit_tick(bit_tick),
		.load(timer_load),
		.load_bits(load_bits),
		.expired(timer_done)
	);

	assign defer_ok = timer_done && !busy;

	// Receive classification on the incoming stream
	logic [15:0] ri_reg;
	logic [15:0] type_reg;
	logic vlan_reg;
	logic [15:0] len_reg;
	logic ia_ok_reg;
	logic bc_reg;
	logic arp_hi_reg;
	logic arp_lo_reg;
	logic is_fc_reg;
	logic [2:0] prio_reg;
	logic [15:0] vofs;
	logic [7:0] ia_byte;
	logic [7:0] ul_mask;

	assign vofs = vlan_reg ? mcb_pkg::VLAN_EXTRA : 16'h0000;
	assign ia_byte = individual_station_address[8*(5 - ri_reg[2:0]) +: 8];
	assign ul_mask = (ri_reg == 16'h0000 && b15[mcb_pkg::IGN_UL_BIT]) ? 8'hFD : 8'hFF;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ri_reg <= 16'h0000;
			type_reg <= 16'h0000;
			vlan_reg <= 1'b0;
			len_reg <= 16'h0000;
			ia_ok_reg <= 1'b1;
			bc_reg <= 1'b1;
			arp_hi_reg <= 1'b0;
			arp_lo_reg <= 1'b0;
			is_fc_reg <= 1'b0;
			prio_reg <= 3'h0;
		end
		else if (rx_valid)
		begin
			ri_reg <= rx_last ? 16'h0000 : ri_reg + 16'h0001;
			if (ri_reg == 16'h0000)
			begin
				ia_ok_reg <= (rx_data & ul_mask) == (ia_byte & ul_mask);
				bc_reg <= rx_data == 8'hFF;
				vlan_reg <= 1'b0;
				arp_hi_reg <= 1'b0;
				arp_lo_reg <= 1'b0;
				is_fc_reg <= 1'b0;
			end
			else if (ri_reg < 16'h0006)
			begin
				ia_ok_reg <= ia_ok_reg && (rx_data & ul_mask) == (ia_byte & ul_mask);
				bc_reg <= bc_reg && rx_data == 8'hFF;
			end
			if (ri_reg == 16'h000C || ri_reg == 16'h0010)
				type_reg[15:8] <= rx_data;
			if (ri_reg == 16'h000D)
			begin
				vlan_reg <= {type_reg[15:8], rx_data} == mcb_pkg::TYPE_VLAN;
				len_reg <= {type_reg[15:8], rx_data};
				is_fc_reg <= {type_reg[15:8], rx_data} == mcb_pkg::TYPE_FC;
			end
			if (ri_reg == 16'h0011 && vlan_reg)
			begin
				len_reg <= {type_reg[15:8], rx_data};
				is_fc_reg <= {type_reg[15:8], rx_data} == mcb_pkg::TYPE_FC;
			end
			if (ri_reg == mcb_pkg::ARP_HI_OFS + vofs)
				arp_hi_reg <= rx_data == ip_hi;
			if (ri_reg == mcb_pkg::ARP_LO_OFS + vofs)
				arp_lo_reg <= rx_data == ip_lo;
			if (ri_reg == mcb_pkg::PRIO_OFS + vofs)
				prio_reg <= rx_data[2:0];
		end
	end

	// Frame status at the last byte
	logic accept;
	logic too_long;

	assign accept = b15[mcb_pkg::PROMISC_BIT] || ia_ok_reg
		|| (bc_reg && !b15[mcb_pkg::BC_DIS_BIT]);
	assign too_long = ri_reg + 16'h0001 > mcb_pkg::MAX_DATA + mcb_pkg::FCS_HDR_LEN + vofs;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_stat_valid <= 1'b0;
			rx_stat_accept <= 1'b0;
			rx_stat_long <= 1'b0;
			rx_stat_ok <= 1'b0;
			rx_stat_arp_match <= 1'b0;
			rx_stat_pause_low <= 1'b0;
		end
		else
		begin
			rx_stat_valid <= rx_valid && rx_last;
			if (rx_valid && rx_last)
			begin
				rx_stat_accept <= accept;
				rx_stat_long <= too_long;
				rx_stat_ok <= !too_long || b18[mcb_pkg::LONG_OK_BIT];
				rx_stat_arp_match <= arp_hi_reg && arp_lo_reg;
				rx_stat_pause_low <= is_fc_reg && pfc_thr != mcb_pkg::PFC_OFF && prio_reg > pfc_thr;
			end
		end
	end

	// FCS separation and stripping on the host side
	mcb_byte_if rx_in_b ();
	mcb_byte_if rx_dl_b ();

	assign rx_in_b.valid = rx_valid;
	assign rx_in_b.data = rx_data;
	assign rx_in_b.last = rx_last;
	assign rx_in_b.fcs = 1'b0;

	mcb_rx_delay u_rx_delay
	(
		.clk(clk),
		.rst_b(rst_b),
		.in_b(rx_in_b.snk),
		.out_b(rx_dl_b.src)
	);

	logic [15:0] ro_reg;
	logic strip_on;
	logic keep;
	logic crc_xfer;

	assign crc_xfer = b18[mcb_pkg::CRC_XFER_BIT];
	assign strip_on = b18[mcb_pkg::STRIP_EN_BIT] && !crc_xfer && len_reg != 16'h0000
		&& len_reg <= mcb_pkg::MAX_DATA;
	assign keep = rx_dl_b.fcs ? crc_xfer
		: (!strip_on || ro_reg < mcb_pkg::HDR_LEN + vofs + len_reg);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ro_reg <= 16'h0000;
			rx_out_valid <= 1'b0;
			rx_out_data <= 8'h00;
			rx_out_last <= 1'b0;
		end
		else
		begin
			if (rx_dl_b.valid)
				ro_reg <= rx_dl_b.last ? 16'h0000 : ro_reg + 16'h0001;
			rx_out_valid <= rx_dl_b.valid && (keep || rx_dl_b.last);
			rx_out_data <= rx_dl_b.data;
			rx_out_last <= rx_dl_b.valid && rx_dl_b.last;
		end
	end

	// Transmit: pad and append FCS
	logic [31:0] crc_reg;
	logic [6:0] tcnt_reg;
	logic [4:0] fcnt_reg;
	logic adv;
	logic pad_needed;
	logic [31:0] crc_fin;
	logic [4:0] fcs_bytes;

	assign adv = !tx_out_valid || tx_out_ready;
	assign tx_in_ready = tx_state_reg == TX_DATA && adv;
	// Compared without the +1, so a saturated count cannot wrap into padding
	assign pad_needed = b18[mcb_pkg::PAD_EN_BIT] && tcnt_reg < mcb_pkg::MIN_NO_FCS - 7'h01;
	assign crc_fin = short_crc_select ? {16'h0000, ~crc_reg[15:0]} : ~crc_reg;
	assign fcs_bytes = short_crc_select ? 5'h02 : mcb_pkg::FCS_LEN;

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d, input logic s);
		return s ? {16'h0000, mcb_pkg::short_crc_select_byte(c[15:0], d)} : mcb_pkg::crc32_byte(c, d);
	endfunction : crc_step

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_state_reg <= TX_IDLE;
			crc_reg <= 32'hFFFFFFFF;
			tcnt_reg <= 7'h00;
			fcnt_reg <= 5'h00;
			tx_out_valid <= 1'b0;
			tx_out_data <= 8'h00;
			tx_out_last <= 1'b0;
		end
		else
		begin
			if (tx_out_ready)
				tx_out_valid <= 1'b0;
			case (tx_state_reg)
				TX_IDLE:
				begin
					crc_reg <= 32'hFFFFFFFF;
					tcnt_reg <= 7'h00;
					fcnt_reg <= 5'h00;
					if (tx_in_valid && defer_ok)
						tx_state_reg <= TX_DATA;
				end
				TX_DATA:
				begin
					if (adv && tx_in_valid)
					begin
						tx_out_valid <= 1'b1;
						tx_out_data <= tx_in_data;
						tx_out_last <= 1'b0;
						crc_reg <= crc_step(crc_reg, tx_in_data, short_crc_select);
						if (tcnt_reg != 7'h7F)
							tcnt_reg <= tcnt_reg + 7'h01;
						if (tx_in_last)
							tx_state_reg <= pad_needed ? TX_PAD : TX_FCS;
					end
				end
				TX_PAD:
				begin
					if (adv)
					begin
						tx_out_valid <= 1'b1;
						tx_out_data <= mcb_pkg::PAD_BYTE;
						crc_reg <= crc_step(crc_reg, mcb_pkg::PAD_BYTE, short_crc_select);
						tcnt_reg <= tcnt_reg + 7'h01;
						if (!pad_needed)
							tx_state_reg <= TX_FCS;
					end
				end
				TX_FCS:
				begin
					if (adv)
					begin
						tx_out_valid <= 1'b1;
						tx_out_data <= crc_fin[8*fcnt_reg[1:0] +: 8];
						fcnt_reg <= fcnt_reg + 5'h01;
						tx_out_last <= fcnt_reg + 5'h01 == fcs_bytes;
						if (fcnt_reg + 5'h01 == fcs_bytes)
							tx_state_reg <= TX_IDLE;
					end
				end
				default:
					tx_state_reg <= TX_IDLE;
			endcase
		end
	end
endmodule : mcb_mac_cfg

// ==== verif/mcb_phy.sv ====
`timescale 1ns/100ps
module mcb_phy
(
	input wire logic clk,
	input wire logic stall,
	input wire logic tx_out_valid,
	input wire logic [7:0] tx_out_data,
	input wire logic tx_out_last,
	output logic tx_out_ready,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_last,
	output logic carrier_sense_pin
);
	logic [7:0] rx_q[$];
	logic [7:0] tx_q[$];
	initial
	begin
		tx_out_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
		carrier_sense_pin = 1'b0;
	end
	// Stall drops ready on every other cycle
	always @(negedge clk)
		tx_out_ready <= stall ? !tx_out_ready : 1'b1;
	always @(posedge clk)
		if (tx_out_valid && tx_out_ready)
			tx_q.push_back(tx_out_data);
	task automatic send();
		carrier_sense_pin = 1'b1;
		foreach (rx_q[i])
		begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_data = rx_q[i];
			rx_last = i == rx_q.size() - 1;
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_last = 1'b0;
		// Released line must not keep the last byte
		rx_data = ~rx_data;
		carrier_sense_pin = 1'b0;
		repeat (8) @(negedge clk);
	endtask : send
endmodule : mcb_phy

// ==== verif/mcb_mac_cfg_assertions.sv ====
`timescale 1ns/100ps
module mcb_mac_cfg_assertions
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cfg_commit,
	input wire logic carrier_sense_pin,
	input wire logic rx_valid,
	input wire logic rx_last,
	input wire logic rx_out_valid,
	input wire logic rx_out_last,
	input wire logic rx_stat_valid,
	input wire logic tx_in_valid,
	input wire logic tx_in_ready,
	input wire logic tx_out_valid,
	input wire logic [7:0] tx_out_data,
	input wire logic tx_out_last,
	input wire logic tx_out_ready,
	input wire logic defer_ok,
	input wire logic modified_backoff,
	input wire logic short_crc_select,
	input wire logic priority_fc_enable,
	input wire logic [15:0] fc_pause_time
);
	logic [1:0] since_reg;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Masks the default load on the first edges after reset
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			since_reg <= 2'h0;
		else if (since_reg != 2'h3)
			since_reg <= since_reg + 2'h1;
	a_fc_time_hold:
	assert property (since_reg == 2'h3 && !$past(cfg_commit, 2) |-> $stable(fc_pause_time))
		else $error("pause time changed without commit");
	a_cfg_out_cause:
	assert property (since_reg == 2'h3 && $changed({short_crc_select, modified_backoff, priority_fc_enable})
		|-> $past(cfg_commit, 2))
		else $error("config output changed without commit");
	a_stat_one_pulse:
	assert property (rx_valid && rx_last |=> rx_stat_valid ##1 !rx_stat_valid)
		else $error("status pulse missing or long");
	a_rx_end_mark:
	assert property (rx_valid && rx_last |-> ##[1:6] (rx_out_valid && rx_out_last))
		else $error("frame end marker missing");
	a_tx_out_hold:
	assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable({tx_out_data, tx_out_last}))
		else $error("transmit byte not held");
	a_tx_stall_refuse:
	assert property (tx_out_valid && !tx_out_ready |-> !tx_in_ready)
		else $error("host byte taken while stalled");
	a_tx_take_out:
	assert property (tx_in_valid && tx_in_ready |=> tx_out_valid)
		else $error("taken byte not presented");
	a_carrier_defer:
	assert property (carrier_sense_pin [*3] |-> !defer_ok)
		else $error("defer open during carrier");
endmodule : mcb_mac_cfg_assertions
bind mcb_mac_cfg mcb_mac_cfg_assertions mcb_mac_cfg_assertions_i (.clk, .rst_b, .cfg_commit, .carrier_sense_pin,
	.rx_valid, .rx_last, .rx_out_valid, .rx_out_last, .rx_stat_valid, .tx_in_valid, .tx_in_ready, .tx_out_valid,
	.tx_out_data, .tx_out_last, .tx_out_ready, .defer_ok, .modified_backoff, .short_crc_select,
	.priority_fc_enable, .fc_pause_time);

// ==== verif/tb.sv ====
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0, rst_b = 1'b0, cfg_wr = 1'b0, cfg_commit = 1'b0, stall = 1'b0;
	logic backoff_done = 1'b0, collision_detect_input = 1'b0, tx_in_valid = 1'b0, tx_in_last = 1'b0;
	logic [4:0] cfg_idx = 5'h00;
	logic [7:0] cfg_data = 8'h00, tx_in_data = 8'h00, rx_data, rx_out_data, tx_out_data;
	logic [47:0] individual_station_address = 48'h021122334455;
	logic carrier_sense_pin, rx_valid, rx_last, rx_out_valid, rx_out_last, rx_stat_valid, rx_stat_accept;
	logic rx_stat_long, rx_stat_ok, rx_stat_arp_match, rx_stat_pause_low, tx_in_ready, tx_out_valid;
	logic tx_out_last, tx_out_ready, defer_ok, modified_backoff, short_crc_select, priority_fc_enable;
	logic [15:0] fc_pause_time;
	logic [63:0] cb = 64'h72400080F2006000;
	logic [7:0] opt [6] = '{8'h80, 8'h90, 8'h80, 8'h82, 8'h83, 8'h81};
	logic [47:0] da [6] = '{48'h001122334455, 48'h001122334455, '1, '1, '1, 48'h00AABBCCDDEE};
	logic acc [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
	int n_errors = 0, n_checks = 0, n_out = 0, gap = 0, n_base = 0, n_bo = 0;
	mcb_mac_cfg mcb_mac_cfg_i (.clk, .rst_b, .cfg_wr, .cfg_idx, .cfg_data, .cfg_commit, .individual_station_address,
		.carrier_sense_pin, .collision_detect_input, .backoff_done, .rx_valid, .rx_data, .rx_last, .rx_out_valid,
		.rx_out_data, .rx_out_last, .rx_stat_valid, .rx_stat_accept, .rx_stat_long, .rx_stat_ok, .rx_stat_arp_match,
		.rx_stat_pause_low, .tx_in_valid, .tx_in_data, .tx_in_last, .tx_in_ready, .tx_out_valid, .tx_out_data,
		.tx_out_last, .tx_out_ready, .defer_ok, .modified_backoff, .short_crc_select, .priority_fc_enable,
		.fc_pause_time);
	mcb_phy mcb_phy_i (.clk, .stall, .tx_out_valid, .tx_out_data, .tx_out_last, .tx_out_ready, .rx_valid,
		.rx_data, .rx_last, .carrier_sense_pin);
	initial
		forever #5 clk = ~clk;
	// Host bytes delivered, and closed-defer cycles since the medium went quiet
	always @(posedge clk)
	begin
		n_out <= n_out + int'(rx_out_valid && !rx_out_last);
		gap <= (carrier_sense_pin || tx_out_valid) ? 0 : gap + int'(!defer_ok);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_rng(input int got, input int lo);
		n_checks++;
		if (got < lo || got > lo + 4)
		begin
			n_errors++;
			$display("Error %0t: defer %0d cycles, expected from %0d", $time, got, lo);
		end
	endtask : chk_rng
	function automatic logic [31:0] crc32(input logic [7:0] q[$], input int n);
		logic [31:0] r;
		r = 32'hFFFFFFFF;
		for (int i = 0; i < n; i++)
			for (int b = 0; b < 8; b++)
				r = (r >> 1) ^ ((r[0] ^ q[i][b]) ? 32'hEDB88320 : 32'h00000000);
		return ~r;
	endfunction : crc32
	task automatic apply(input logic go);
		for (int i = 0; i < 8; i++)
		begin
			cfg_idx = 5'(11 + i);
			cfg_data = cb[8 * i +: 8];
			cfg_wr = 1'b1;
			@(negedge clk);
		end
		cfg_wr = 1'b0;
		cfg_commit = go;
		@(negedge clk);
		cfg_commit = 1'b0;
		repeat (3) @(negedge clk);
	endtask : apply
	task automatic build(input logic [47:0] d, input logic [15:0] ty, input int len);
		mcb_phy_i.rx_q.delete();
		for (int i = 0; i < len - 4; i++)
			mcb_phy_i.rx_q.push_back(i < 6 ? d[47 - 8 * i -: 8] : i < 12 ? 8'h02 : 8'h00);
		mcb_phy_i.rx_q[12] = ty[15:8];
		mcb_phy_i.rx_q[13] = ty[7:0];
	endtask : build
	task automatic go();
		logic [31:0] c;
		c = crc32(mcb_phy_i.rx_q, mcb_phy_i.rx_q.size());
		for (int i = 0; i < 4; i++)
			mcb_phy_i.rx_q.push_back(c[8 * i +: 8]);
		n_base = n_out;
		mcb_phy_i.send();
	endtask : go
	task automatic tx(input int n, input int exp);
		mcb_phy_i.tx_q.delete();
		for (int i = 0; i < n; i++)
		begin
			tx_in_valid = 1'b1;
			tx_in_data = 8'(i + 1);
			tx_in_last = i == n - 1;
			// Ready is judged at the edge that takes the byte
			@(posedge clk);
			for (int w = 0; w < 2000 && !tx_in_ready; w++)
				@(posedge clk);
			@(negedge clk);
		end
		tx_in_valid = 1'b0;
		tx_in_last = 1'b0;
		for (int w = 0; w < 500 && mcb_phy_i.tx_q.size() < exp; w++)
			@(negedge clk);
		repeat (8) @(negedge clk);
		chk(mcb_phy_i.tx_q.size(), exp);
	endtask : tx
	task automatic dfr(input logic [15:0] b, input logic t, input int lo);
		cb[15:0] = b;
		apply(1'b1);
		if (t)
			tx(20, 64);
		else
		begin
			build('1, 16'h0800, 64);
			go();
		end
		repeat (700) @(negedge clk);
		chk_rng(gap, lo);
	endtask : dfr
	task automatic complete_run();
		$display("TB: %0d checks, %0d errors", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk(fc_pause_time, 16'h4000);
		chk({short_crc_select, modified_backoff, priority_fc_enable}, 3'h0);
		cb[63:32] = 32'h321234A4;
		apply(1'b0);
		chk(fc_pause_time, 16'h4000);
		apply(1'b1);
		chk(fc_pause_time, 16'h1234);
		chk({short_crc_select, modified_backoff, priority_fc_enable}, 3'h7);
		tx(20, 62);
		$display("TB: config test done");
		cb[39:32] = 8'h80;
		apply(1'b1);
		stall = 1'b1;
		tx(20, 64);
		stall = 1'b0;
		for (int i = 20; i < 60; i++)
			chk(mcb_phy_i.tx_q[i], 8'h7E);
		chk({mcb_phy_i.tx_q[63], mcb_phy_i.tx_q[62], mcb_phy_i.tx_q[61], mcb_phy_i.tx_q[60]},
			crc32(mcb_phy_i.tx_q, 60));
		cb[63:56] = 8'h30;
		apply(1'b1);
		tx(20, 24);
		$display("TB: transmit test done");
		for (int k = 0; k < 6; k++)
		begin
			cb[39:32] = opt[k];
			apply(1'b1);
			build(da[k], 16'h0800, 64);
			go();
			chk(rx_stat_accept, acc[k]);
		end
		cb[31:16] = 16'h5678;
		apply(1'b1);
		for (int k = 0; k < 3; k++)
		begin
			build('1, k == 1 ? 16'h8100 : 16'h0806, 64);
			mcb_phy_i.rx_q[16] = 8'h08;
			mcb_phy_i.rx_q[17] = 8'h06;
			mcb_phy_i.rx_q[k == 1 ? 44 : 40] = k == 2 ? 8'h78 : 8'h56;
			mcb_phy_i.rx_q[k == 1 ? 45 : 41] = k == 2 ? 8'h56 : 8'h78;
			go();
			chk(rx_stat_arp_match, k != 2);
		end
		$display("TB: filter test done");
		cb[63:56] = 8'h32;
		apply(1'b1);
		for (int p = 3; p < 6; p += 2)
		begin
			build(48'h0180C2000001, 16'h8808, 64);
			mcb_phy_i.rx_q[19] = 8'(p);
			go();
			chk(rx_stat_pause_low, p > 3);
		end
		for (int k = 0; k < 3; k++)
		begin
			cb[63:56] = k == 2 ? 8'h3A : 8'h32;
			apply(1'b1);
			build('1, 16'h0800, k == 0 ? 1518 : 1519);
			go();
			chk({rx_stat_long, rx_stat_ok}, k == 0 ? 2'b01 : k == 1 ? 2'b10 : 2'b11);
		end
		for (int k = 0; k < 3; k++)
		begin
			cb[63:56] = k == 0 ? 8'h33 : k == 1 ? 8'h32 : 8'h37;
			apply(1'b1);
			build('1, 16'h0014, 64);
			go();
			chk(n_out - n_base, k == 0 ? 34 : k == 1 ? 60 : 63);
		end
		$display("TB: receive test done");
		dfr(16'h6001, 1'b0, 96);
		dfr(16'h6101, 1'b0, 608);
		dfr(16'h6001, 1'b1, 608);
		dfr(16'h3000, 1'b0, 48);
		cb[15:0] = 16'h6001;
		apply(1'b1);
		backoff_done = 1'b1;
		@(negedge clk);
		backoff_done = 1'b0;
		for (int w = 0; w < 600; w++)
		begin
			n_bo += int'(!defer_ok);
			@(negedge clk);
		end
		chk_rng(n_bo, 512);
		$display("TB: defer test done");
		complete_run();
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		n_errors++;
		complete_run();
	end
endmodule : tb
